// >>> design/nth_pkg.sv
// shared constants and types of the tag host buffer handshake block
package nth_pkg;
	localparam int          BUF_DEPTH_DEF     = 3000;
	localparam int          TMP_DEPTH_DEF     = 256;
	localparam logic [7:0]  OFS_CTRL          = 8'h00;
	localparam logic [7:0]  OFS_STATUS        = 8'h04;
	localparam logic [7:0]  OFS_INT_EN        = 8'h08;
	localparam logic [7:0]  OFS_INT_FLAG      = 8'h0C;
	localparam logic [7:0]  OFS_FILE_ID       = 8'h10;
	localparam logic [7:0]  OFS_FILE_OFS      = 8'h14;
	localparam logic [7:0]  OFS_BLK_LEN       = 8'h18;
	localparam logic [7:0]  OFS_BUF_START     = 8'h1C;
	localparam logic [7:0]  OFS_HOST_RESP     = 8'h20;
	localparam logic [7:0]  OFS_CUSTOM_SW     = 8'h24;
	localparam logic [7:0]  OFS_BUF_ADDR      = 8'h28;
	localparam logic [7:0]  OFS_BUF_DATA      = 8'h2C;
	localparam int          CTRL_AUTOACK_BIT  = 8;
	localparam int          FLAG_GEN_BIT      = 0;
	localparam int          FLAG_PF_BIT       = 1;
	localparam int          RESP_SERVICED_BIT = 0;
	localparam int          RESP_CUSTOM_BIT   = 1;
	localparam int          RESP_EXTRA_BIT    = 2;
	localparam logic        AUTOACK_RST       = 1'b0;
	localparam logic [1:0]  INT_EN_RST        = 2'h0;
	localparam logic [15:0] CUSTOM_SW_RST     = 16'h0000;
	localparam logic [15:0] SW_OK             = 16'h9000;
	localparam logic [7:0]  MAX_BLOCK         = 8'hFF;
	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_SELECT,
		CMD_READ,
		CMD_UPDATE
	} nth_cmd_t;
endpackage

// >>> design/nth_copy_seq.sv
// index sequencer that walks a block copy one byte per cycle
module nth_copy_seq
	import nth_pkg::*;
#(
	parameter int IW = 12
) (
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          start,
	input  wire logic [IW-1:0] srcBase,
	input  wire logic [IW-1:0] count,
	output logic               we_q,
	output logic [IW-1:0]      src_q,
	output logic [IW-1:0]      dst_q,
	output logic               done_q
);
	logic [IW-1:0] left_q;

	if (IW < 2) begin : g_chk
		$error("nth_copy_seq: IW too small");
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			we_q   <= 1'b0;
			src_q  <= '0;
			dst_q  <= '0;
			left_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				src_q  <= srcBase;
				dst_q  <= '0;
				left_q <= count;
				we_q   <= (count != '0);
				done_q <= (count == '0);
			end else if (we_q) begin
				if (left_q == IW'(1)) begin
					we_q   <= 1'b0;
					done_q <= 1'b1;
				end else begin
					src_q  <= src_q + IW'(1);
					dst_q  <= dst_q + IW'(1);
					left_q <= left_q - IW'(1);
				end
			end
		end
	end
endmodule

// >>> design/nth_buffer_handshake.sv
// tag-side buffer and host interrupt handshake with an apb register slave
// Summary of operation
// R01: in prefetch mode extra host data is appended after the data already held
// R02: at the buffer limit unsent bytes move to index zero, only missing requested
// R03: the missing-data request after a shift uses the general interrupt
// R04: a read needing host data loads request registers, then interrupts
// R05: once the read response starts going out, the prefetch interrupt is raised
// R06: a read fully held in the buffer raises only the prefetch interrupt
// R07: host cancels a prefetch by answering with a length of zero
// R08: prefetched data not needed by a different request is thrown away
// R09: an update packet loads request registers, then the general interrupt
// R10: the file-identifier register shows the file chosen by the last select
// R11: host reads the status command field before acting on a request
// R12: write packets always report buffer start zero; host reads length bytes
// R13: host clears the flag before setting the serviced field
// R14: host loads the custom word and sets the custom select bit
// R15: blocking write answers 90h 00h unless the custom word was chosen
// R16: blocking write holds the packet until serviced, reusing the same region
// R17: nonblocking write acknowledges 90h 00h on receipt, then interrupts
// R18: nonblocking mode only while the automatic acknowledge bit is set
// R19: nonblocking packets land in a temporary buffer, copied once host is free
// R20: host should drain each packet before the next one fully arrives
// R21: automatic acknowledge is control bit 8, reset zero
// R22: after prefetch host writes added length, then sets extra-data-done
// R23: interrupt output stays high while any enabled flag is set
//
// The register addresses and the APB interface to the registers were decided locally.
module nth_buffer_handshake
	import nth_pkg::*;
#(
	parameter int BUF_DEPTH = BUF_DEPTH_DEF,
	parameter int TMP_DEPTH = TMP_DEPTH_DEF
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rfCmdValid,
	input  wire nth_cmd_t    rfCmdKind,
	input  wire logic [15:0] rfFileId,
	input  wire logic [15:0] rfOffset,
	input  wire logic [7:0]  rfLength,
	input  wire logic        rfWrByteValid,
	input  wire logic [7:0]  rfWrByte,
	input  wire logic        rfTxStart,
	input  wire logic [11:0] rfRdAddr,
	output logic [7:0]       rfRdData,
	output logic             rspValid,
	output logic [15:0]      rspSw,
	output logic [11:0]      rspStart,
	output logic [7:0]       rspLen,
	output logic             hostIrq
);
	localparam int IW = $clog2(BUF_DEPTH);
	localparam int TW = $clog2(TMP_DEPTH);
	localparam logic [IW:0] DEPTH_W = (IW+1)'(BUF_DEPTH);

	if (IW != 12 || TW < 8 || TW > IW) begin : g_chk
		$error("nth_buffer_handshake: unsupported buffer depths");
	end

	typedef enum logic [2:0] {
		S_IDLE, S_SHIFT, S_COPY, S_WAITGEN, S_WAITTX, S_WAITPF
	} nth_state_t;

	logic [7:0]    mem [BUF_DEPTH];
	logic [7:0]    tmp [TMP_DEPTH];
	nth_state_t    st_q;
	nth_cmd_t      cmd_q;
	logic          autoAck_q, customSel_q, pendCopy_q;
	logic          setGen_q, setPf_q, shStart_q, cpStart_q;
	logic [1:0]    intEn_q, flags_q;
	logic [15:0]   fileId_q, fileOfs_q, headOfs_q, customSw_q;
	logic [7:0]    blkLen_q, reqLen_q, wrCnt_q, pendLen_q;
	logic [IW-1:0] bufStart_q, fillEnd_q, sentEnd_q, bufAddr_q, cpLen_q;
	logic [IW-1:0] shSrc, shDst, tcSrc, tcDst;
	logic          shWe, shDone, tcWe, tcDone;
	logic          done, wr, hit, servicedW, extraW, memWrRf, idleCmd;
	logic          readHit, readPart;
	logic [31:0]   rdMux;
	logic [IW:0]   needEnd;
	logic [IW-1:0] have, space;

	// apb handshake: one wait state, effects at the completing edge
	assign done      = psel && penable && pready;
	assign wr        = done && pwrite;
	assign servicedW = wr && paddr == OFS_HOST_RESP && pwdata[RESP_SERVICED_BIT];
	assign extraW    = wr && paddr == OFS_HOST_RESP && pwdata[RESP_EXTRA_BIT];
	assign idleCmd   = rfCmdValid && (st_q == S_IDLE || st_q == S_WAITPF);
	assign needEnd   = {1'b0, sentEnd_q} + (IW+1)'(rfLength);
	assign have      = fillEnd_q - sentEnd_q;
	assign space     = IW'(DEPTH_W - {1'b0, fillEnd_q});
	assign readHit   = rfOffset == headOfs_q && needEnd <= {1'b0, fillEnd_q};
	assign readPart  = rfOffset == headOfs_q && have != '0;
	// blocking packet is held while the host services it
	assign memWrRf   = rfWrByteValid && !autoAck_q && st_q != S_WAITGEN; // see R16

	always_comb begin
		hit   = 1'b1;
		rdMux = 32'h0000_0000;
		unique case (paddr)
			OFS_CTRL:      rdMux[CTRL_AUTOACK_BIT] = autoAck_q;
			OFS_STATUS:    rdMux = {28'h0, st_q != S_IDLE, 1'b0, cmd_q};
			OFS_INT_EN:    rdMux = {30'h0, intEn_q};
			OFS_INT_FLAG:  rdMux = {30'h0, flags_q};
			OFS_FILE_ID:   rdMux = {16'h0, fileId_q}; // see R10
			OFS_FILE_OFS:  rdMux = {16'h0, fileOfs_q};
			OFS_BLK_LEN:   rdMux = {24'h0, blkLen_q};
			OFS_BUF_START: rdMux = {20'h0, bufStart_q};
			OFS_HOST_RESP: rdMux = {30'h0, customSel_q, 1'b0};
			OFS_CUSTOM_SW: rdMux = {16'h0, customSw_q};
			OFS_BUF_ADDR:  rdMux = {20'h0, bufAddr_q};
			OFS_BUF_DATA:  rdMux = {24'h0, mem[bufAddr_q]};
			default:       hit   = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (psel && penable && !pready) begin
				pready  <= 1'b1;
				prdata  <= pwrite ? 32'h0000_0000 : rdMux;
				pslverr <= !hit;
			end
		end
	end

	// software controls
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			autoAck_q  <= AUTOACK_RST; // see R21
			intEn_q    <= INT_EN_RST;
			customSw_q <= CUSTOM_SW_RST;
			bufAddr_q  <= '0;
		end else begin
			if (wr && paddr == OFS_CTRL)
				autoAck_q <= pwdata[CTRL_AUTOACK_BIT]; // see R21
			if (wr && paddr == OFS_INT_EN)
				intEn_q <= pwdata[1:0];
			if (wr && paddr == OFS_CUSTOM_SW)
				customSw_q <= pwdata[15:0];
			if (wr && paddr == OFS_BUF_ADDR)
				bufAddr_q <= pwdata[IW-1:0];
			else if (done && paddr == OFS_BUF_DATA)
				bufAddr_q <= bufAddr_q + IW'(1);
		end
	end

	// sticky flags, write one to clear, a new event wins over the clear
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			flags_q <= 2'b00;
			hostIrq <= 1'b0;
		end else begin
			if (wr && paddr == OFS_INT_FLAG)
				flags_q <= flags_q & ~pwdata[1:0];
			if (setGen_q)
				flags_q[FLAG_GEN_BIT] <= 1'b1; // see R04
			if (setPf_q)
				flags_q[FLAG_PF_BIT] <= 1'b1; // see R05
			hostIrq <= |(flags_q & intEn_q); // see R23
		end
	end

	// buffers: copies first, then rf packet bytes, then host data port
	always_ff @(posedge clk_sys) begin
		if (shWe)
			mem[shDst] <= mem[shSrc]; // see R02
		else if (tcWe)
			mem[tcDst] <= tmp[tcSrc[TW-1:0]]; // see R19
		else if (memWrRf)
			mem[IW'(wrCnt_q)] <= rfWrByte; // see R16
		else if (wr && paddr == OFS_BUF_DATA)
			mem[bufAddr_q] <= pwdata[7:0]; // see R01
	end

	always_ff @(posedge clk_sys) begin
		if (rfWrByteValid && autoAck_q)
			tmp[TW'(wrCnt_q)] <= rfWrByte; // see R19
		rfRdData <= mem[rfRdAddr];
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			wrCnt_q <= 8'h00;
		else if (rfCmdValid)
			wrCnt_q <= 8'h00;
		else if (rfWrByteValid && (autoAck_q || memWrRf))
			wrCnt_q <= wrCnt_q + 8'h01;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			customSel_q <= 1'b0;
		else if (wr && paddr == OFS_HOST_RESP)
			customSel_q <= pwdata[RESP_CUSTOM_BIT];
		else if (rspValid)
			customSel_q <= 1'b0;
	end

	nth_copy_seq #(.IW(IW)) u_shift (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.start   (shStart_q),
		.srcBase (sentEnd_q),
		.count   (cpLen_q),
		.we_q    (shWe),
		.src_q   (shSrc),
		.dst_q   (shDst),
		.done_q  (shDone)
	);

	nth_copy_seq #(.IW(IW)) u_tcopy (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.start   (cpStart_q),
		.srcBase ('0),
		.count   (cpLen_q),
		.we_q    (tcWe),
		.src_q   (tcSrc),
		.dst_q   (tcDst),
		.done_q  (tcDone)
	);

	// request handling and rf responses
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			cmd_q <= CMD_NONE;
			fileId_q <= 16'h0000;
			fileOfs_q <= 16'h0000;
			headOfs_q <= 16'h0000;
			blkLen_q <= 8'h00;
			reqLen_q <= 8'h00;
			pendLen_q <= 8'h00;
			bufStart_q <= '0;
			fillEnd_q <= '0;
			sentEnd_q <= '0;
			cpLen_q <= '0;
			pendCopy_q <= 1'b0;
			setGen_q <= 1'b0;
			setPf_q <= 1'b0;
			shStart_q <= 1'b0;
			cpStart_q <= 1'b0;
			rspValid <= 1'b0;
			rspSw <= SW_OK;
			rspStart <= '0;
			rspLen <= 8'h00;
		end else begin
			setGen_q <= 1'b0;
			setPf_q <= 1'b0;
			shStart_q <= 1'b0;
			cpStart_q <= 1'b0;
			rspValid <= 1'b0;
			if (wr && paddr == OFS_BLK_LEN)
				blkLen_q <= pwdata[7:0];
			// uncommitted extra data is simply never counted in fillEnd
			if (idleCmd) begin // see R08
				cmd_q <= rfCmdKind;
				unique case (rfCmdKind)
					CMD_SELECT: begin
						fileId_q <= rfFileId; // see R10
						rspValid <= 1'b1;
						rspSw <= SW_OK;
						rspLen <= 8'h00;
						st_q <= S_IDLE;
					end
					CMD_READ: begin
						fileOfs_q <= rfOffset;
						reqLen_q <= rfLength;
						if (readHit) begin
							rspValid <= 1'b1; // see R06
							rspSw <= SW_OK;
							rspStart <= sentEnd_q;
							rspLen <= rfLength;
							sentEnd_q <= IW'(needEnd);
							headOfs_q <= rfOffset + 16'(rfLength);
							st_q <= S_WAITTX;
						end else if (readPart && needEnd > DEPTH_W) begin
							cpLen_q <= have; // see R02
							shStart_q <= 1'b1;
							st_q <= S_SHIFT;
						end else if (readPart) begin
							bufStart_q <= fillEnd_q;
							blkLen_q <= rfLength - have[7:0];
							setGen_q <= 1'b1; // see R04
							st_q <= S_WAITGEN;
						end else begin
							fillEnd_q <= '0; // see R08
							sentEnd_q <= '0;
							headOfs_q <= rfOffset;
							bufStart_q <= '0;
							blkLen_q <= rfLength;
							setGen_q <= 1'b1; // see R04
							st_q <= S_WAITGEN;
						end
					end
					CMD_UPDATE: begin
						fileOfs_q <= rfOffset;
						fillEnd_q <= '0;
						sentEnd_q <= '0;
						headOfs_q <= 16'hFFFF;
						if (autoAck_q) begin // see R18
							rspValid <= 1'b1; // see R17
							rspSw <= SW_OK;
							rspLen <= 8'h00;
							cpLen_q <= IW'(wrCnt_q);
							blkLen_q <= wrCnt_q;
							cpStart_q <= 1'b1; // see R19
							st_q <= S_COPY;
						end else begin
							bufStart_q <= '0; // see R12
							blkLen_q <= wrCnt_q;
							setGen_q <= 1'b1; // see R09
							st_q <= S_WAITGEN;
						end
					end
					default: st_q <= st_q;
				endcase
			end else begin
				unique case (st_q)
					S_SHIFT: if (shDone) begin
						sentEnd_q <= '0; // see R02
						fillEnd_q <= cpLen_q;
						bufStart_q <= cpLen_q;
						blkLen_q <= reqLen_q - cpLen_q[7:0];
						setGen_q <= 1'b1; // see R03
						st_q <= S_WAITGEN;
					end
					S_COPY: if (tcDone) begin
						bufStart_q <= '0; // see R12
						setGen_q <= 1'b1; // see R17
						st_q <= S_WAITGEN;
					end
					S_WAITGEN: begin
						if (rfCmdValid && rfCmdKind == CMD_UPDATE
							&& autoAck_q) begin
							rspValid <= 1'b1; // see R17
							rspSw <= SW_OK;
							rspLen <= 8'h00;
							pendCopy_q <= 1'b1; // see R19
							pendLen_q <= wrCnt_q;
							fileOfs_q <= rfOffset;
						end
						if (servicedW && cmd_q == CMD_READ) begin
							rspValid <= 1'b1;
							rspSw <= customSel_q ? customSw_q : SW_OK;
							rspStart <= sentEnd_q;
							rspLen <= customSel_q ? 8'h00 : reqLen_q;
							if (customSel_q) begin
								st_q <= S_IDLE;
							end else begin
								fillEnd_q <= bufStart_q + IW'(blkLen_q);
								sentEnd_q <= sentEnd_q + IW'(reqLen_q);
								headOfs_q <= headOfs_q + 16'(reqLen_q);
								st_q <= S_WAITTX;
							end
						end else if (servicedW) begin
							if (!autoAck_q) begin
								rspValid <= 1'b1; // see R15
								rspSw <= customSel_q ? customSw_q : SW_OK;
								rspLen <= 8'h00;
							end
							if (pendCopy_q) begin
								pendCopy_q <= 1'b0;
								cpLen_q <= IW'(pendLen_q);
								blkLen_q <= pendLen_q;
								cpStart_q <= 1'b1; // see R19
								st_q <= S_COPY;
							end else begin
								st_q <= S_IDLE;
							end
						end
					end
					S_WAITTX: if (rfTxStart) begin
						bufStart_q <= fillEnd_q; // see R01
						blkLen_q <= space > IW'(MAX_BLOCK) ? MAX_BLOCK
							: space[7:0];
						fileOfs_q <= headOfs_q + 16'(have);
						setPf_q <= 1'b1; // see R05
						st_q <= S_WAITPF;
					end
					S_WAITPF: if (extraW) begin
						fillEnd_q <= fillEnd_q + IW'(blkLen_q); // see R01
						st_q <= S_IDLE;
					end
					default: st_q <= st_q;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_gen_flag;
		setGen_q |=> flags_q[FLAG_GEN_BIT] && !setGen_q;
	endproperty
	a_gen_flag: assert property (p_gen_flag) // see R04
		else $error("general flag not set after request load");

	property p_irq_release;
		(flags_q == 2'b00)[*2] |-> !hostIrq;
	endproperty
	a_irq_release: assert property (p_irq_release) // see R23
		else $error("interrupt stays high with no flag");

	property p_irq_hold;
		(|(flags_q & intEn_q)) ##1 (|(flags_q & intEn_q)) |-> hostIrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) // see R23
		else $error("interrupt low while enabled flag set");

	property p_cached;
		idleCmd && rfCmdKind == CMD_READ && readHit
			|=> rspValid && !setGen_q ##1 !setGen_q;
	endproperty
	a_cached: assert property (p_cached) // see R06
		else $error("cached read raised general request");

	property p_prefetch;
		st_q == S_WAITTX && rfTxStart && !idleCmd
			|=> setPf_q ##1 flags_q[FLAG_PF_BIT];
	endproperty
	a_prefetch: assert property (p_prefetch) // see R05
		else $error("prefetch flag missing after tx start");

	property p_shift;
		st_q == S_SHIFT && shDone
			|=> setGen_q && !setPf_q && sentEnd_q == '0;
	endproperty
	a_shift: assert property (p_shift) // see R03
		else $error("shift did not end in general request");

	property p_autoack;
		idleCmd && rfCmdKind == CMD_UPDATE && autoAck_q
			|=> rspValid && rspSw == SW_OK && !setGen_q;
	endproperty
	a_autoack: assert property (p_autoack) // see R17
		else $error("nonblocking write not acknowledged at once");

	property p_custom;
		st_q == S_WAITGEN && servicedW && cmd_q == CMD_UPDATE
			&& !autoAck_q && !rfCmdValid
			|=> rspValid && rspSw == ($past(customSel_q)
				? $past(customSw_q) : SW_OK);
	endproperty
	a_custom: assert property (p_custom) // see R15
		else $error("wrong status word for blocking write");

	property p_wr_start;
		setGen_q && cmd_q == CMD_UPDATE |-> bufStart_q == '0;
	endproperty
	a_wr_start: assert property (p_wr_start) // see R12
		else $error("write packet start index not zero");

	property p_hold;
		st_q == S_WAITGEN && !autoAck_q && rfWrByteValid && !rfCmdValid
			|=> $stable(wrCnt_q);
	endproperty
	a_hold: assert property (p_hold) // see R16
		else $error("blocking packet overwritten before service");

	property p_select;
		idleCmd && rfCmdKind == CMD_SELECT
			|=> fileId_q == $past(rfFileId) && rspValid;
	endproperty
	a_select: assert property (p_select) // see R10
		else $error("file identifier not updated by select");

	c_cached: cover property (idleCmd && rfCmdKind == CMD_READ && readHit);
	c_shift: cover property (st_q == S_SHIFT ##[1:300] shDone);
	c_pend: cover property (pendCopy_q ##[1:300] st_q == S_COPY);
endmodule

// >>> tb/nth_reader_model.sv
// reader-side model: sends commands, update packets and transmit starts
module nth_reader_model
	import nth_pkg::*;
(
	input  wire logic   clk_sys,
	output logic        rfCmdValid,
	output nth_cmd_t    rfCmdKind,
	output logic [15:0] rfFileId,
	output logic [15:0] rfOffset,
	output logic [7:0]  rfLength,
	output logic        rfWrByteValid,
	output logic [7:0]  rfWrByte,
	output logic        rfTxStart,
	output logic [11:0] rfRdAddr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		rfCmdValid = 1'b0;
		rfCmdKind = CMD_NONE;
		rfFileId = 16'h0000;
		rfOffset = 16'h0000;
		rfLength = 8'h00;
		rfWrByteValid = 1'b0;
		rfWrByte = 8'h00;
		rfTxStart = 1'b0;
		rfRdAddr = 12'h000;
	end

	task automatic sendCmd(input nth_cmd_t k, input logic [15:0] f,
		input logic [15:0] o, input logic [7:0] n);
		@(posedge clk_sys);
		rfCmdValid <= 1'b1;
		rfCmdKind <= k;
		rfFileId <= f;
		rfOffset <= o;
		rfLength <= n;
		@(posedge clk_sys);
		// released fields stop showing the last value
		rfCmdValid <= 1'b0;
		rfCmdKind <= CMD_NONE;
		rfFileId <= ~f;
		rfOffset <= ~o;
		rfLength <= ~n;
	endtask

	// one packet byte per cycle, values counting up from b
	task automatic sendPkt(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			rfWrByteValid <= 1'b1;
			rfWrByte <= b + 8'(i);
		end
		@(posedge clk_sys);
		rfWrByteValid <= 1'b0;
		rfWrByte <= ~rfWrByte;
	endtask

	task automatic txStart();
		@(posedge clk_sys);
		rfTxStart <= 1'b1;
		@(posedge clk_sys);
		rfTxStart <= 1'b0;
	endtask

	// point the rf read port at one buffer index
	task automatic peek(input logic [11:0] a);
		@(posedge clk_sys);
		rfRdAddr <= a;
	endtask
endmodule

// >>> tb/nth_buffer_handshake_test.sv
// self-checking bench: host over apb, reader model on the rf side
module nth_buffer_handshake_test
	import nth_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] x;
		logic        e;
	} nth_row_t;

	logic        clk_sys = 1'b0;
	logic        rstn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, s, k;
	logic        pready, pslverr, e;
	logic        rfCmdValid, rfWrByteValid, rfTxStart, rspValid, hostIrq;
	nth_cmd_t    rfCmdKind;
	logic [15:0] rfFileId, rfOffset, rspSw;
	logic [7:0]  rfLength, rfWrByte, rfRdData, rspLen;
	logic [11:0] rfRdAddr, rspStart;
	int          badCount = 0;
	int          numChecks = 0;
	nth_row_t    rows [7] = '{
		'{OFS_CTRL, 32'h00000100, 32'h00000100, 1'b0},
		'{OFS_CTRL, 32'h00000000, 32'h00000000, 1'b0},
		'{OFS_INT_EN, 32'h00000003, 32'h00000003, 1'b0},
		'{OFS_CUSTOM_SW, 32'h00006A82, 32'h00006A82, 1'b0},
		'{OFS_BLK_LEN, 32'h000001A5, 32'h000000A5, 1'b0},
		'{OFS_BUF_ADDR, 32'h00001005, 32'h00000005, 1'b0},
		'{8'hF0, 32'h00000005, 32'h00000000, 1'b1}};

	always #5 clk_sys = ~clk_sys;

	nth_buffer_handshake nth_buffer_handshake_i (.*);
	nth_reader_model nth_reader_model_i (.*);

	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, badCount);
		if (badCount == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		numChecks++;
		if (g !== x) begin
			badCount++;
			$display("MISMATCH at %0t got %0h expected %0h", $time, g, x);
		end
	endtask

	task automatic hang();
		chk(32'h0, 32'h1);
		conclude();
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) hang();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	task automatic waitIrq(input logic v);
		for (int n = 0; n < 300 && hostIrq !== v; n++) begin
			@(posedge clk_sys);
		end
		chk({31'h0, hostIrq}, {31'h0, v});
		if (hostIrq !== v) hang();
	endtask

	task automatic waitRsp(input logic [15:0] sw, input logic [7:0] len);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rspValid !== 1'b1 && n < 8);
		if (rspValid !== 1'b1) hang();
		chk({16'h0, rspSw}, {16'h0, sw});
		chk({24'h0, rspLen}, {24'h0, len});
	endtask

	task automatic fill(input logic [31:0] a, input logic [7:0] b, input int n);
		wr(OFS_BUF_ADDR, a);
		for (int i = 0; i < n; i++) begin
			wr(OFS_BUF_DATA, {24'h0, b + 8'(i)});
		end
	endtask

	task automatic service(input logic [31:0] f, input logic [31:0] rsp);
		wr(OFS_INT_FLAG, f);
		waitIrq(1'b0);
		wr(OFS_HOST_RESP, rsp);
	endtask

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		$display("register table done");
		nth_reader_model_i.sendCmd(CMD_SELECT, 16'hE104, 16'h0, 8'h0);
		waitRsp(SW_OK, 8'h0);
		rd(OFS_FILE_ID, 32'hE104);
		$display("select done");
		nth_reader_model_i.sendPkt(8'h30, 3);
		nth_reader_model_i.sendCmd(CMD_UPDATE, 16'hE104, 16'h40, 8'h3);
		waitIrq(1'b1);
		rd(OFS_INT_FLAG, 32'h1);
		rd(OFS_STATUS, 32'hB);
		rd(OFS_BUF_START, 32'h0);
		rd(OFS_BLK_LEN, 32'h3);
		rd(OFS_FILE_OFS, 32'h40);
		wr(OFS_BUF_ADDR, 32'h0);
		for (int i = 0; i < 3; i++) begin
			rd(OFS_BUF_DATA, 32'h30 + i);
		end
		wr(OFS_CUSTOM_SW, 32'h6A82);
		wr(OFS_HOST_RESP, 32'h2);
		service(32'h1, 32'h1);
		waitRsp(16'h6A82, 8'h0);
		wr(OFS_CTRL, 32'h100);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_INT_EN, 32'h0);
		chk({16'h0, rspSw}, {16'h0, SW_OK});
		wr(OFS_INT_EN, 32'h3);
		$display("reset done");
		nth_reader_model_i.sendPkt(8'h50, 2);
		nth_reader_model_i.sendCmd(CMD_UPDATE, 16'hE104, 16'h43, 8'h2);
		waitIrq(1'b1);
		wr(OFS_BUF_ADDR, 32'h0);
		nth_reader_model_i.sendPkt(8'h90, 1);
		rd(OFS_BUF_DATA, 32'h50);
		service(32'h1, 32'h1);
		waitRsp(SW_OK, 8'h0);
		$display("blocking write done");
		wr(OFS_CTRL, 32'h100);
		nth_reader_model_i.sendPkt(8'h70, 2);
		nth_reader_model_i.sendCmd(CMD_UPDATE, 16'hE104, 16'h0, 8'h2);
		waitRsp(SW_OK, 8'h0);
		waitIrq(1'b1);
		nth_reader_model_i.sendPkt(8'h80, 2);
		nth_reader_model_i.sendCmd(CMD_UPDATE, 16'hE104, 16'h2, 8'h2);
		waitRsp(SW_OK, 8'h0);
		wr(OFS_BUF_ADDR, 32'h0);
		rd(OFS_BUF_DATA, 32'h70);
		rd(OFS_BUF_DATA, 32'h71);
		service(32'h1, 32'h1);
		waitIrq(1'b1);
		wr(OFS_BUF_ADDR, 32'h0);
		rd(OFS_BUF_DATA, 32'h80);
		service(32'h1, 32'h1);
		wr(OFS_CTRL, 32'h0);
		$display("nonblocking write done");
		nth_reader_model_i.sendCmd(CMD_READ, 16'hE104, 16'h0, 8'h4);
		waitIrq(1'b1);
		rd(OFS_INT_FLAG, 32'h1);
		apb(1'b0, OFS_BUF_START, 32'h0);
		s = r;
		fill(s, 8'hA0, 4);
		wr(OFS_BLK_LEN, 32'h4);
		service(32'h1, 32'h1);
		waitRsp(SW_OK, 8'h4);
		chk({20'h0, rspStart}, s);
		nth_reader_model_i.txStart();
		waitIrq(1'b1);
		rd(OFS_INT_FLAG, 32'h2);
		rd(OFS_BUF_START, s + 4);
		fill(s + 4, 8'hA4, 4);
		wr(OFS_BLK_LEN, 32'h4);
		service(32'h2, 32'h4);
		nth_reader_model_i.sendCmd(CMD_READ, 16'hE104, 16'h4, 8'h4);
		waitRsp(SW_OK, 8'h4);
		chk({20'h0, rspStart}, s + 4);
		rd(OFS_INT_FLAG, 32'h0);
		nth_reader_model_i.txStart();
		waitIrq(1'b1);
		wr(OFS_BLK_LEN, 32'h0);
		service(32'h2, 32'h4);
		rd(OFS_STATUS, 32'h2);
		nth_reader_model_i.sendCmd(CMD_READ, 16'hE104, 16'h64, 8'h2);
		waitIrq(1'b1);
		rd(OFS_INT_FLAG, 32'h1);
		rd(OFS_BUF_START, 32'h0);
		fill(32'h0, 8'hC0, 2);
		wr(OFS_BLK_LEN, 32'h2);
		service(32'h1, 32'h1);
		waitRsp(SW_OK, 8'h2);
		$display("read path done");
		// keep appending extra data until the buffer end forces a shift
		k = 32'h66;
		for (int i = 0; i < 12; i++) begin
			nth_reader_model_i.txStart();
			waitIrq(1'b1);
			s = 32'h2 + 32'(i) * 32'hFF;
			rd(OFS_BUF_START, s);
			fill(s, 8'hD0, 2);
			s = 32'(BUF_DEPTH_DEF) - s;
			if (s > 32'hFF) s = 32'hFF;
			rd(OFS_BLK_LEN, s);
			wr(OFS_BLK_LEN, s);
			service(32'h2, 32'h4);
			nth_reader_model_i.sendCmd(CMD_READ, 16'hE104, k[15:0], 8'hFF);
			if (i < 11) waitRsp(SW_OK, 8'hFF);
			k = k + 32'hFF;
		end
		waitIrq(1'b1);
		rd(OFS_INT_FLAG, 32'h1);
		rd(OFS_BUF_START, 32'hC1);
		rd(OFS_BLK_LEN, 32'h3E);
		wr(OFS_BUF_ADDR, 32'h0);
		rd(OFS_BUF_DATA, 32'hD0);
		rd(OFS_BUF_DATA, 32'hD1);
		nth_reader_model_i.peek(12'h001);
		repeat (2) @(posedge clk_sys);
		chk({24'h0, rfRdData}, 32'hD1);
		wr(OFS_BLK_LEN, 32'h3E);
		service(32'h1, 32'h1);
		waitRsp(SW_OK, 8'hFF);
		chk({20'h0, rspStart}, 32'h0);
		$display("shift done");
		conclude();
	end
endmodule
